// ==== hdl/lcst_map.svh ====
// Purpose: Constants of the lifecycle transit command handler
// Assumes: Included by the design files by bare name
// Notes:   Offsets, codes and field values only
`ifndef LCST_MAP_SVH
`define LCST_MAP_SVH
// ----------------------------------------
// Framing bytes
// ----------------------------------------
`define LCST_SOH         8'h01
`define LCST_ETX         8'h03
`define LCST_SOD         8'h81
`define LCST_CMD_TRANSIT 8'h71
`define LCST_RES_ERR     8'hf1
`define LCST_LEN_CMD     16'h0003
`define LCST_RSP_LNH     8'h00
`define LCST_RSP_LNL     8'h0a
`define LCST_RSP_LAST    4'he
`define LCST_ALL_ONES    32'hffffffff
// ----------------------------------------
// Lifecycle codes
// ----------------------------------------
`define LCST_LC_CM       8'h01
`define LCST_LC_OEM      8'h04
`define LCST_LC_LCKB     8'h06
`define LCST_LC_RACK     8'h08
`define LCST_LC_RRET     8'h09
// ----------------------------------------
// Status codes
// ----------------------------------------
`define LCST_STS_OK      8'h00
`define LCST_STS_PKT     8'hc1
`define LCST_STS_SUM     8'hc2
`define LCST_STS_ACC     8'hc3
`define LCST_STS_PARAM   8'hc4
`define LCST_STS_PROT    8'hc5
`define LCST_STS_FLASH   8'hc6
`define LCST_STS_HW      8'hc7
`endif

// ==== hdl/lcst_pkg.sv ====
// Purpose: Types of the lifecycle transit command handler
// Assumes: Nothing
// Notes:   Enumerations only
package lcst_pkg;
   typedef enum logic [2:0] {
      rx_hunt, rx_lnh, rx_lnl, rx_body, rx_sum, rx_etx
   } lcst_rx_t;
   typedef enum logic [2:0] {
      st_idle, st_check, st_flash, st_readback, st_send, st_wait, st_halt
   } lcst_state_t;
endpackage : lcst_pkg

// ==== hdl/lcst_sum.sv ====
// Purpose: Running byte sum modulo 256
// Assumes: One byte per add strobe
// Notes:   Clear wins over add
`timescale 1ns/1ps
`default_nettype none
module lcst_sum (
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic       i_clear,
   input  wire logic       i_add,
   input  wire logic [7:0] i_byte,
   output var  logic [7:0] o_sum
);
   always_ff @(posedge i_clk) begin
      if (i_srst || i_clear) begin
         o_sum <= 8'h00;
      end else if (i_add) begin
         o_sum <= o_sum + i_byte;
      end
   end
endmodule : lcst_sum
`default_nettype wire

// ==== hdl/lcst_transit.sv ====
// Purpose: Lifecycle state transit command handler
// Assumes: Byte streams and flash port share i_clk
// Notes:   Handles only command 71h, other codes are dropped unless the end byte is bad or the length is zero or above LEN_MAX
`timescale 1ns/1ps
`default_nettype none
`include "lcst_map.svh"
module lcst_transit #(
   parameter logic [15:0] LEN_MAX = 16'h0400
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   output var  logic        o_rx_ready,
   output var  logic        o_tx_valid,
   output var  logic [7:0]  o_tx_data,
   input  wire logic        i_tx_ready,
   input  wire logic [7:0]  i_lifecycle_state,
   input  wire logic        i_lckboot_enable,
   input  wire logic        i_edw_pending,
   input  wire logic        i_prot_abnormal,
   output var  logic        o_flash_req,
   output var  logic [7:0]  o_flash_dest,
   input  wire logic        i_flash_done,
   input  wire logic        i_flash_err,
   input  wire logic [31:0] i_flash_status,
   output var  logic        o_halted,
   output var  lcst_pkg::lcst_state_t o_state
);
   import lcst_pkg::*;

   if (LEN_MAX < `LCST_LEN_CMD) begin : g_len_chk
      $error("LEN_MAX below command length");
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lcst_rx_t    rx_reg;
   lcst_state_t st_reg;
   logic [7:0]  lnh_reg;
   logic [15:0] len_reg;
   logic [15:0] cnt_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  src_reg;
   logic [7:0]  dst_reg;
   logic        cmd_seen_reg;
   logic        etx_ok_reg;
   logic        sum_ok_reg;
   logic        done_reg;
   logic        halt_after_reg;
   logic [7:0]  res_reg;
   logic [7:0]  sts_reg;
   logic [31:0] det_reg;
   logic        tx_start_reg;
   logic [7:0]  sum;
   logic        take;
   logic        fmt_ok;
   logic        tx_done;
   logic        sum_clear;
   logic        sum_add;
   logic        go_flash;
   logic [7:0]  chk_sts;
   logic        ignore;
   logic        lc_valid;

   // ----------------------------------------
   // Receive side
   // ----------------------------------------
   // Bytes are held off while a packet is in work, so none is lost
   assign o_rx_ready = ((st_reg == st_idle) && !done_reg) || (st_reg == st_halt);
   assign take       = i_rx_valid && o_rx_ready && (st_reg == st_idle);
   assign sum_clear  = take && (rx_reg == rx_hunt);
   assign sum_add    = take && (rx_reg != rx_hunt) && (rx_reg != rx_etx);
   assign fmt_ok     = (len_reg != 16'h0000) && (len_reg <= LEN_MAX);

   lcst_sum u_sum (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_clear (sum_clear),
      .i_add   (sum_add),
      .i_byte  (i_rx_data),
      .o_sum   (sum)
   );

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rx_reg <= rx_hunt;
      end else if (take) begin
         case (rx_reg)
            rx_hunt: begin
               if (i_rx_data == `LCST_SOH) begin
                  rx_reg <= rx_lnh;
               end
            end
            rx_lnh: begin
               rx_reg <= rx_lnl;
            end
            rx_lnl: begin
               // An unusable length skips the body, so framing still closes
               if (({lnh_reg, i_rx_data} != 16'h0000) && ({lnh_reg, i_rx_data} <= LEN_MAX)) begin
                  rx_reg <= rx_body;
               end else begin
                  rx_reg <= rx_sum;
               end
            end
            rx_body: begin
               if (cnt_reg == len_reg - 16'h0001) begin
                  rx_reg <= rx_sum;
               end
            end
            rx_sum: begin
               rx_reg <= rx_etx;
            end
            rx_etx: begin
               rx_reg <= rx_hunt;
            end
            default: begin
               rx_reg <= rx_hunt;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         lnh_reg <= 8'h00;
         len_reg <= 16'h0000;
         cnt_reg <= 16'h0000;
      end else if (take) begin
         if (rx_reg == rx_lnh) begin
            lnh_reg <= i_rx_data;
         end
         if (rx_reg == rx_lnl) begin
            len_reg <= {lnh_reg, i_rx_data};
            cnt_reg <= 16'h0000;
         end
         if (rx_reg == rx_body) begin
            cnt_reg <= cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cmd_reg      <= 8'h00;
         src_reg      <= 8'h00;
         dst_reg      <= 8'h00;
         cmd_seen_reg <= 1'b0;
      end else if (sum_clear) begin
         cmd_seen_reg <= 1'b0;
      end else if (take && (rx_reg == rx_body)) begin
         case (cnt_reg)
            16'h0000: begin
               cmd_reg      <= i_rx_data;
               cmd_seen_reg <= 1'b1;
            end
            16'h0001: src_reg <= i_rx_data;
            16'h0002: dst_reg <= i_rx_data;
            default: begin
               cmd_reg <= cmd_reg;
            end
         endcase
      end
   end

   // Packet complete once the end-byte slot has been taken
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         etx_ok_reg <= 1'b0;
         sum_ok_reg <= 1'b0;
         done_reg   <= 1'b0;
      end else begin
         done_reg <= take && (rx_reg == rx_etx);
         if (take && (rx_reg == rx_etx)) begin
            etx_ok_reg <= (i_rx_data == `LCST_ETX);
            sum_ok_reg <= (sum == 8'h00);
         end
      end
   end

   // ----------------------------------------
   // Checks in fixed order
   // ----------------------------------------
   assign ignore = etx_ok_reg && fmt_ok && cmd_seen_reg && (cmd_reg != `LCST_CMD_TRANSIT);

   always_comb begin
      go_flash = 1'b0;
      if (!etx_ok_reg) begin
         chk_sts = `LCST_STS_PKT;
      end else if (!sum_ok_reg) begin
         chk_sts = `LCST_STS_SUM;
      end else if (!fmt_ok) begin
         chk_sts = `LCST_STS_PKT;
      end else if (len_reg != `LCST_LEN_CMD) begin
         chk_sts = `LCST_STS_PKT;
      end else if ((i_lifecycle_state != `LCST_LC_CM) && (i_lifecycle_state != `LCST_LC_OEM)
                   && (i_lifecycle_state != `LCST_LC_RACK)) begin
         chk_sts = `LCST_STS_ACC;
      end else if (i_edw_pending) begin
         chk_sts = `LCST_STS_ACC;
      end else if (src_reg != i_lifecycle_state) begin
         chk_sts = `LCST_STS_PARAM;
      end else if (!(((src_reg == `LCST_LC_CM) && (dst_reg == `LCST_LC_OEM))
                  || ((src_reg == `LCST_LC_OEM) && (dst_reg == `LCST_LC_LCKB))
                  || ((src_reg == `LCST_LC_RACK) && (dst_reg == `LCST_LC_RRET)))) begin
         chk_sts = `LCST_STS_PARAM;
      end else if ((dst_reg == `LCST_LC_LCKB) && !i_lckboot_enable) begin
         chk_sts = `LCST_STS_PROT;
      end else begin
         chk_sts  = `LCST_STS_OK;
         go_flash = 1'b1;
      end
   end

   assign lc_valid = (i_lifecycle_state == `LCST_LC_CM) || (i_lifecycle_state == `LCST_LC_OEM)
                  || (i_lifecycle_state == `LCST_LC_LCKB) || (i_lifecycle_state == `LCST_LC_RACK)
                  || (i_lifecycle_state == `LCST_LC_RRET);

   // ----------------------------------------
   // Control sequence
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_reg <= st_idle;
      end else begin
         case (st_reg)
            st_idle: begin
               if (i_lifecycle_state == `LCST_LC_LCKB) begin
                  st_reg <= st_halt;
               end else if (done_reg) begin
                  st_reg <= ignore ? st_idle : st_check;
               end
            end
            st_check: begin
               st_reg <= go_flash ? st_flash : st_send;
            end
            st_flash: begin
               if (i_flash_done) begin
                  st_reg <= i_flash_err ? st_send : st_readback;
               end
            end
            st_readback: begin
               st_reg <= st_send;
            end
            st_send: begin
               st_reg <= st_wait;
            end
            st_wait: begin
               if (tx_done) begin
                  st_reg <= halt_after_reg ? st_halt : st_idle;
               end
            end
            st_halt: begin
               st_reg <= st_halt;
            end
            default: begin
               st_reg <= st_idle;
            end
         endcase
      end
   end

   // Flash request is a single pulse per accepted command
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_flash_req  <= 1'b0;
         o_flash_dest <= 8'h00;
      end else begin
         o_flash_req <= (st_reg == st_check) && go_flash;
         if ((st_reg == st_check) && go_flash) begin
            o_flash_dest <= dst_reg;
         end
      end
   end

   // ----------------------------------------
   // Answer contents
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         res_reg        <= `LCST_RES_ERR;
         sts_reg        <= `LCST_STS_OK;
         det_reg        <= `LCST_ALL_ONES;
         halt_after_reg <= 1'b0;
      end else begin
         case (st_reg)
            st_check: begin
               res_reg        <= `LCST_RES_ERR;
               sts_reg        <= chk_sts;
               det_reg        <= `LCST_ALL_ONES;
               halt_after_reg <= 1'b0;
            end
            st_flash: begin
               if (i_flash_done && i_flash_err) begin
                  sts_reg <= `LCST_STS_FLASH;
                  det_reg <= i_flash_status;
               end
            end
            st_readback: begin
               if (!lc_valid) begin
                  sts_reg        <= `LCST_STS_HW;
                  halt_after_reg <= 1'b1;
               end else if (i_prot_abnormal) begin
                  sts_reg <= `LCST_STS_HW;
               end else begin
                  res_reg        <= `LCST_CMD_TRANSIT;
                  sts_reg        <= `LCST_STS_OK;
                  halt_after_reg <= (dst_reg == `LCST_LC_LCKB) || (dst_reg == `LCST_LC_RRET);
               end
            end
            default: begin
               res_reg <= res_reg;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         tx_start_reg <= 1'b0;
      end else begin
         tx_start_reg <= (st_reg == st_send);
      end
   end

   // ----------------------------------------
   // Transmit side
   // ----------------------------------------
   lcst_tx u_tx (
      .i_clk      (i_clk),
      .i_srst     (i_srst),
      .i_start    (tx_start_reg),
      .i_res      (res_reg),
      .i_sts      (sts_reg),
      .i_det      (det_reg),
      .o_busy     (),
      .o_done     (tx_done),
      .o_tx_valid (o_tx_valid),
      .o_tx_data  (o_tx_data),
      .i_tx_ready (i_tx_ready)
   );

   assign o_halted = (st_reg == st_halt);
   assign o_state  = st_reg;

endmodule : lcst_transit
`default_nettype wire

// ==== hdl/lcst_tx.sv ====
// Purpose: Serialises the fifteen byte answer packet
// Assumes: Start only while not busy
// Notes:   Words go out high byte first
`timescale 1ns/1ps
`default_nettype none
`include "lcst_map.svh"
module lcst_tx (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_start,
   input  wire logic [7:0]  i_res,
   input  wire logic [7:0]  i_sts,
   input  wire logic [31:0] i_det,
   output var  logic        o_busy,
   output var  logic        o_done,
   output var  logic        o_tx_valid,
   output var  logic [7:0]  o_tx_data,
   input  wire logic        i_tx_ready
);
   logic [3:0]  idx_reg;
   logic [7:0]  res_reg;
   logic [7:0]  sts_reg;
   logic [31:0] det_reg;
   logic [7:0]  sum;

   function automatic logic [7:0] pick(input logic [3:0] i, input logic [7:0] r, input logic [7:0] s,
                                       input logic [31:0] d, input logic [7:0] c);
      case (i)
         4'h0:    pick = `LCST_SOD;
         4'h1:    pick = `LCST_RSP_LNH;
         4'h2:    pick = `LCST_RSP_LNL;
         4'h3:    pick = r;
         4'h4:    pick = s;
         4'h5:    pick = d[31:24];
         4'h6:    pick = d[23:16];
         4'h7:    pick = d[15:8];
         4'h8:    pick = d[7:0];
         4'hd:    pick = c;
         4'he:    pick = `LCST_ETX;
         default: pick = 8'hff;
      endcase
   endfunction : pick

   // Address word is all ones, four bytes of ff add fc
   assign sum = 8'h00 - (`LCST_RSP_LNL + res_reg + sts_reg + det_reg[31:24] + det_reg[23:16]
                + det_reg[15:8] + det_reg[7:0] + 8'hfc);
   assign o_tx_valid = o_busy;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
         idx_reg <= 4'h0;
         o_tx_data <= 8'h00;
         res_reg <= 8'h00;
         sts_reg <= 8'h00;
         det_reg <= 32'h0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            o_busy    <= 1'b1;
            idx_reg   <= 4'h0;
            o_tx_data <= `LCST_SOD;
            res_reg   <= i_res;
            sts_reg   <= i_sts;
            det_reg   <= i_det;
         end else if (o_busy && i_tx_ready) begin
            if (idx_reg == `LCST_RSP_LAST) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end else begin
               idx_reg   <= idx_reg + 4'h1;
               o_tx_data <= pick(idx_reg + 4'h1, res_reg, sts_reg, det_reg, sum);
            end
         end
      end
   end
endmodule : lcst_tx
`default_nettype wire

// ==== tb/lcst_flash_mdl.sv ====
// Purpose: Flash controller and lifecycle store facing the handler
// Assumes: One state write per request
// Notes:   Status lines toggle while no answer is held
`timescale 1ns/1ps
`default_nettype none
module lcst_flash_mdl (
   input  wire logic        i_clk,
   input  wire logic        i_load,
   input  wire logic [7:0]  i_load_state,
   input  wire logic        i_fail,
   input  wire logic        i_corrupt,
   input  wire logic [3:0]  i_delay,
   input  wire logic [31:0] i_status,
   input  wire logic        i_flash_req,
   input  wire logic [7:0]  i_flash_dest,
   output var  logic [7:0]  o_state,
   output var  logic        o_done,
   output var  logic        o_err,
   output var  logic [31:0] o_status
);
   logic [7:0] dest_reg;
   logic [3:0] cnt_reg;
   logic       busy_reg;
   // ----------------------------------------
   // Store and answer
   // ----------------------------------------
   always_ff @(posedge i_clk) begin
      o_done <= 1'b0;
      if (i_load) begin
         o_state  <= i_load_state;
         busy_reg <= 1'b0;
         o_err    <= 1'b0;
         o_status <= 32'h0;
      end else if (i_flash_req) begin
         busy_reg <= 1'b1;
         cnt_reg  <= i_delay;
         dest_reg <= i_flash_dest;
      end else if (busy_reg && cnt_reg == 4'h0) begin
         busy_reg <= 1'b0;
         o_done   <= 1'b1;
         o_err    <= i_fail;
         o_status <= i_status;
         // Failed write leaves the old state
         if (!i_fail) begin
            o_state <= i_corrupt ? 8'h5a : dest_reg;
         end
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
      end else begin
         o_err    <= ~o_err;
         o_status <= ~o_status;
      end
   end
endmodule : lcst_flash_mdl
`default_nettype wire

// ==== tb/lcst_transit_chk.sv ====
// Purpose: Port checks of the transit handler
// Assumes: Single clock domain
// Notes:   Bound to every instance
`timescale 1ns/1ps
`default_nettype none
module lcst_transit_chk (
   input  wire logic       i_clk,
   input  wire logic       i_srst,
   input  wire logic       o_rx_ready,
   input  wire logic       o_tx_valid,
   input  wire logic [7:0] o_tx_data,
   input  wire logic       i_tx_ready,
   input  wire logic [7:0] i_lifecycle_state,
   input  wire logic       i_lckboot_enable,
   input  wire logic       i_edw_pending,
   input  wire logic       o_flash_req,
   input  wire logic [7:0] o_flash_dest,
   input  wire logic       o_halted
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   flash_pulse_a: assert property (o_flash_req |=> !o_flash_req)
      else $error("flash request held too long");
   busy_closed_a: assert property (o_tx_valid && !o_halted |-> !o_rx_ready)
      else $error("bytes taken while answering");
   halt_sticky_a: assert property (o_halted |=> o_halted)
      else $error("halt released");
   halt_silent_a: assert property ((o_halted && !o_tx_valid) [*3] |=> !o_tx_valid && !o_flash_req)
      else $error("halted block answered");
   answer_start_a: assert property ($rose(o_tx_valid) |-> o_tx_data == 8'h81)
      else $error("answer does not open with data start byte");
   tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("answer byte changed while stalled");
   flash_legal_a: assert property (o_flash_req |-> (i_lifecycle_state == 8'h01 && o_flash_dest == 8'h04) ||
      (i_lifecycle_state == 8'h04 && o_flash_dest == 8'h06 && i_lckboot_enable) ||
      (i_lifecycle_state == 8'h08 && o_flash_dest == 8'h09))
      else $error("illegal transition written");
   no_flash_edw_a: assert property (o_flash_req |-> !i_edw_pending && !o_tx_valid)
      else $error("write started while refused");
   lock_reset_a: assert property ($fell(i_srst) && i_lifecycle_state == 8'h06 |-> ##[0:2] o_halted)
      else $error("boot locked state not halted");
endmodule : lcst_transit_chk
bind lcst_transit lcst_transit_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .o_rx_ready(o_rx_ready),
   .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
   .i_lifecycle_state(i_lifecycle_state), .i_lckboot_enable(i_lckboot_enable),
   .i_edw_pending(i_edw_pending), .o_flash_req(o_flash_req), .o_flash_dest(o_flash_dest), .o_halted(o_halted));
`default_nettype wire

// ==== tb/tb_lifecycle_state_transit_cmd.sv ====
// Purpose: Self-checking bench of the transit handler
// Assumes: Answers come back in command order
// Notes:   Sink stalls at random, flash delay random
`timescale 1ns/1ps
`default_nettype none
`include "lcst_map.svh"
module tb_lifecycle_state_transit_cmd;
   import lcst_pkg::*;
   logic        clk = 0, srst = 1, rx_valid = 0, tx_ready = 0, lck_en = 0, edw = 0, prot = 0;
   logic        ld = 1, fail = 0, corrupt = 0, rx_ready, tx_valid, freq, fdone, ferr, halted;
   logic [7:0]  rx_data = 8'h00, ld_state = 8'h01, tx_data, fdest, lc_state;
   logic [3:0]  dly = 4'h0;
   logic [31:0] fstat = 32'h0, fsts, rng_a = 32'h033d, rng_b = 32'h033d;
   logic [47:0] exp_q[$];
   logic [47:0] w;
   logic [7:0]  got[$];
   logic [7:0]  pk[15];
   logic [7:0]  s;
   lcst_state_t st;
   int          errors = 0, checks_done = 0, cycles = 0;
   localparam logic [31:0] ONES = `LCST_ALL_ONES;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   lcst_transit u_dut (.i_clk(clk), .i_srst(srst), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
      .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
      .i_lifecycle_state(lc_state), .i_lckboot_enable(lck_en), .i_edw_pending(edw), .i_prot_abnormal(prot),
      .o_flash_req(freq), .o_flash_dest(fdest), .i_flash_done(fdone), .i_flash_err(ferr),
      .i_flash_status(fsts), .o_halted(halted), .o_state(st));
   lcst_flash_mdl u_flash (.i_clk(clk), .i_load(ld), .i_load_state(ld_state), .i_fail(fail),
      .i_corrupt(corrupt), .i_delay(dly), .i_status(fstat), .i_flash_req(freq), .i_flash_dest(fdest),
      .o_state(lc_state), .o_done(fdone), .o_err(ferr), .o_status(fsts));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, want);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : stop_test
   // Called at an edge; holds the byte until an edge sees ready
   task automatic put(input logic [7:0] b);
      int n;
      n = 0;
      #1 rx_valid = 1'b1;
      rx_data = b;
      do begin
         @(posedge clk);
         n++;
      end while (rx_ready !== 1'b1 && n < 1000);
   endtask : put
   task automatic cmd(input logic [7:0] ln, c, sc, dc, sadj, etx);
      logic [7:0] p[3];
      logic [7:0] sm;
      p[0] = c;
      p[1] = sc;
      p[2] = dc;
      sm = ln;
      put(8'h01);
      put(8'h00);
      put(ln);
      for (int i = 0; i < ln; i++) begin
         put(p[i]);
         sm += p[i];
      end
      put(8'h00 - sm + sadj);
      put(etx);
      #1 rx_valid = 1'b0;
   endtask : cmd
   task automatic wait_done();
      int n;
      n = 0;
      while ((exp_q.size() != 0 || got.size() != 0) && n < 3000) begin
         @(posedge clk);
         n++;
      end
      if (n == 3000) errors++;
      repeat (3) @(posedge clk);
   endtask : wait_done
   task automatic run(input logic [7:0] sc, dc, ln, sadj, etx, res, sts, input logic [31:0] det);
      rng_a = xs(rng_a);
      dly = rng_a[3:0];
      exp_q.push_back({res, sts, det});
      cmd(ln, `LCST_CMD_TRANSIT, sc, dc, sadj, etx);
      wait_done();
   endtask : run
   task automatic reset_dut(input logic [7:0] lc);
      #1 srst = 1'b1;
      ld = 1'b1;
      ld_state = lc;
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
      ld = 1'b0;
   endtask : reset_dut
   // ----------------------------------------
   // Clock, stalls, timeout
   // ----------------------------------------
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      #1 rng_b = xs(rng_b);
      tx_ready = |rng_b[1:0];
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Answer monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (!srst && tx_valid && tx_ready) begin
         got.push_back(tx_data);
         if (got.size() == 15) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0);
            else begin
               w = exp_q.pop_front();
               pk = '{8'h81, 8'h00, 8'h0a, w[47:40], w[39:32], w[31:24], w[23:16], w[15:8], w[7:0],
                      8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h03};
               s = 8'h00;
               for (int i = 1; i < 13; i++) s += pk[i];
               pk[13] = 8'h00 - s;
               for (int i = 0; i < 13; i++) check(got[i], pk[i]);
               check(got[13], pk[13]);
               check(got[14], pk[14]);
            end
            got.delete();
         end
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      reset_dut(8'h01);
      // Noise before the start byte
      repeat (5) begin
         rng_a = xs(rng_a);
         put(rng_a[7:0] == 8'h01 ? 8'h5a : rng_a[7:0]);
      end
      #1 rx_valid = 1'b0;
      run(8'h01, 8'h04, 8'h03, 8'h00, 8'h03, 8'h71, `LCST_STS_OK, ONES);
      check(lc_state, 8'h04);
      check(st, st_idle);
      run(8'h04, 8'h06, 8'h03, 8'h00, 8'h00, `LCST_RES_ERR, `LCST_STS_PKT, ONES);
      run(8'h04, 8'h06, 8'h03, 8'h01, 8'h00, `LCST_RES_ERR, `LCST_STS_PKT, ONES);
      run(8'h04, 8'h06, 8'h03, 8'h01, 8'h03, `LCST_RES_ERR, `LCST_STS_SUM, ONES);
      run(8'h04, 8'h06, 8'h00, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_PKT, ONES);
      run(8'h04, 8'h06, 8'h02, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_PKT, ONES);
      cmd(8'h01, 8'h2c, 8'h00, 8'h00, 8'h00, 8'h03);
      repeat (40) @(posedge clk);
      #1 edw = 1'b1;
      run(8'h01, 8'h04, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_ACC, ONES);
      #1 edw = 1'b0;
      run(8'h01, 8'h04, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_PARAM, ONES);
      run(8'h04, 8'h09, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_PARAM, ONES);
      run(8'h04, 8'h06, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_PROT, ONES);
      check(lc_state, 8'h04);
      rng_a = xs(rng_a);
      #1 fail = 1'b1;
      lck_en = 1'b1;
      fstat = rng_a;
      run(8'h04, 8'h06, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_FLASH, fstat);
      check(lc_state, 8'h04);
      #1 fail = 1'b0;
      reset_dut(8'h08);
      #1 prot = 1'b1;
      run(8'h08, 8'h09, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_HW, ONES);
      check(halted, 1'b0);
      #1 prot = 1'b0;
      run(8'h09, 8'h04, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_ACC, ONES);
      reset_dut(8'h08);
      run(8'h08, 8'h09, 8'h03, 8'h00, 8'h03, 8'h71, `LCST_STS_OK, ONES);
      check(halted, 1'b1);
      cmd(8'h03, 8'h71, 8'h09, 8'h04, 8'h00, 8'h03);
      repeat (60) @(posedge clk);
      check(got.size(), 0);
      reset_dut(8'h04);
      #1 corrupt = 1'b1;
      run(8'h04, 8'h06, 8'h03, 8'h00, 8'h03, `LCST_RES_ERR, `LCST_STS_HW, ONES);
      check(halted, 1'b1);
      #1 corrupt = 1'b0;
      reset_dut(8'h06);
      repeat (3) @(posedge clk);
      check(halted, 1'b1);
      cmd(8'h03, 8'h71, 8'h06, 8'h09, 8'h00, 8'h03);
      repeat (60) @(posedge clk);
      check(got.size() + exp_q.size(), 0);
      stop_test();
   end
endmodule : tb_lifecycle_state_transit_cmd
`default_nettype wire
